// ===== design/ahp_power_ctl.v
// Host power and reset switch control driven from two held keys and the host supply sense.
// Assumes keys and sense are raw asynchronous pins; registers over AXI4-Lite.
`timescale 1ns/10ps
`include "ahp_consts.vh"

// Functional notes
// - Power pin stays undriven except during a power pulse, driven at chosen polarity.
// - Reset pin stays undriven except during a reset pulse or while the watchdog bit is set, chosen polarity.
// - Each of power-on, power-off, reset enabled separately; disabled never drives.
// - Host off: confirm held 0.25 s drives power pin for pulse width.
// - Host on: cancel held 4 s drives power pin at least pulse width.
// - Cancel still held after minimum: keep driving up to 5 s more.
// - Host on: confirm held 4 s drives reset pin for 1 s.
// - Right after a reset pulse the device reboots itself.
// - With blanking enabled the display is blanked while sense is low.
// - Fans keep their previous settings while the host is sensed off.
// - Reset pin also carries the watchdog output.
module ahp_power_ctl (
	input  wire        i_clk,
	input  wire        i_rst,
	input  wire        i_sense,
	input  wire        i_key_confirm,
	input  wire        i_key_cancel,
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	output wire        o_pwr_out,
	output wire        o_pwr_oe,
	output wire        o_rst_out,
	output wire        o_rst_oe,
	output wire        o_blank,
	output wire        o_self_reboot,
	output wire [31:0] o_fan_power
);
	// ==========================================
	// Input synchronisers
	wire sense_s;
	wire conf_s;
	wire canc_s;
	ahp_sync u_sense (.i_clk(i_clk), .i_rst(i_rst), .i_d(i_sense),       .o_q(sense_s));
	ahp_sync u_conf  (.i_clk(i_clk), .i_rst(i_rst), .i_d(i_key_confirm), .o_q(conf_s));
	ahp_sync u_canc  (.i_clk(i_clk), .i_rst(i_rst), .i_d(i_key_cancel),  .o_q(canc_s));

	// ==========================================
	// Millisecond tick
	localparam [15:0] TICK_LAST = `AHP_TICK_LAST;
	reg  [15:0] div_reg;
	wire        tick = (div_reg == TICK_LAST);
	always @(posedge i_clk) begin
		if (i_rst || tick) begin
			div_reg <= 16'h0000;
		end else begin
			div_reg <= div_reg + 16'h0001;
		end
	end

	// ==========================================
	// Registers
	reg [31:0] ctrl_reg;
	reg [15:0] width_reg;
	reg [31:0] fan_reg;
	reg        aw_got_reg;
	reg        w_got_reg;
	reg [3:0]  awaddr_reg;
	reg [31:0] wdata_reg;
	reg [3:0]  wstrb_reg;
	reg        bvalid_reg;
	reg [1:0]  bresp_reg;
	reg        rvalid_reg;
	reg [1:0]  rresp_reg;
	reg [31:0] rdata_reg;

	assign s_axi_awready = !aw_got_reg && !bvalid_reg;
	assign s_axi_wready  = !w_got_reg && !bvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;

	wire        aw_now = aw_got_reg | s_axi_awvalid;
	wire        w_now  = w_got_reg | s_axi_wvalid;
	wire [3:0]  wa     = aw_got_reg ? awaddr_reg : s_axi_awaddr;
	wire [31:0] wd     = w_got_reg ? wdata_reg : s_axi_wdata;
	wire [3:0]  ws     = w_got_reg ? wstrb_reg : s_axi_wstrb;
	wire        do_wr  = aw_now && w_now && !bvalid_reg;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  st;
		integer k;
		begin
			merge = old;
			for (k = 0; k < 4; k = k + 1) begin
				if (st[k]) begin
					merge[k*8 +: 8] = nw[k*8 +: 8];
				end
			end
		end
	endfunction

	wire [31:0] width_m = merge({16'h0000, width_reg}, wd, ws);

	always @(posedge i_clk) begin
		if (i_rst) begin
			ctrl_reg   <= `AHP_CTRL_RESET;
			width_reg  <= `AHP_WIDTH_RESET;
			fan_reg    <= `AHP_FAN_RESET;
			aw_got_reg <= 1'b0;
			w_got_reg  <= 1'b0;
			awaddr_reg <= 4'h0;
			wdata_reg  <= 32'h0000_0000;
			wstrb_reg  <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg  <= 2'b00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_got_reg <= 1'b0;
				w_got_reg  <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg  <= 2'b00;
				if (wa == `AHP_CTRL_OFF) begin
					ctrl_reg <= merge(ctrl_reg, wd, ws) & 32'h0000_007f;
				end else if (wa == `AHP_WIDTH_OFF) begin
					width_reg <= width_m[15:0];
				end else if (wa == `AHP_FAN_OFF) begin
					fan_reg <= merge(fan_reg, wd, ws);
				end else if (wa == `AHP_STAT_OFF) begin
					bresp_reg <= 2'b10;
				end else begin
					bresp_reg <= 2'b10;
				end
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// ==========================================
	// Key hold timers and pulse sequencer
	localparam [4:0] ST_IDLE  = 5'b00001;
	localparam [4:0] ST_PON   = 5'b00010;
	localparam [4:0] ST_POFF  = 5'b00100;
	localparam [4:0] ST_EXTRA = 5'b01000;
	localparam [4:0] ST_RST   = 5'b10000;
	localparam [15:0] ON_HOLD  = `AHP_ON_HOLD_MS;
	localparam [15:0] OFF_HOLD = `AHP_OFF_HOLD_MS;
	localparam [15:0] RST_HOLD = `AHP_RST_HOLD_MS;
	localparam [15:0] RST_LEN  = `AHP_RST_PULSE_MS;
	localparam [15:0] EXTRA    = `AHP_EXTRA_MS;

	reg [4:0]  state_reg;
	reg [15:0] conf_cnt_reg;
	reg [15:0] canc_cnt_reg;
	reg [15:0] pulse_cnt_reg;
	reg        reboot_reg;
	reg        wait_rel_reg;

	wire pon_en  = ctrl_reg[`AHP_CTRL_PON_EN];
	wire poff_en = ctrl_reg[`AHP_CTRL_POFF_EN];
	wire rst_en  = ctrl_reg[`AHP_CTRL_RST_EN];
	wire [15:0] conf_lim = sense_s ? RST_HOLD : ON_HOLD;

	always @(posedge i_clk) begin
		if (i_rst) begin
			state_reg     <= ST_IDLE;
			conf_cnt_reg  <= 16'h0000;
			canc_cnt_reg  <= 16'h0000;
			pulse_cnt_reg <= 16'h0000;
			reboot_reg    <= 1'b0;
			wait_rel_reg  <= 1'b0;
		end else begin
			reboot_reg <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (!conf_s && !canc_s) begin
						wait_rel_reg <= 1'b0;
					end
					// Counters restart on release or while waiting for release; the cancel counter also while sense is low.
					if (!conf_s || wait_rel_reg) begin
						conf_cnt_reg <= 16'h0000;
					end else if (tick) begin
						conf_cnt_reg <= conf_cnt_reg + 16'h0001;
					end
					if (!canc_s || !sense_s || wait_rel_reg) begin
						canc_cnt_reg <= 16'h0000;
					end else if (tick) begin
						canc_cnt_reg <= canc_cnt_reg + 16'h0001;
					end
					if (conf_s && !wait_rel_reg && conf_cnt_reg >= conf_lim) begin
						conf_cnt_reg  <= 16'h0000;
						pulse_cnt_reg <= 16'h0000;
						wait_rel_reg  <= 1'b1;
						if (!sense_s && pon_en) begin
							state_reg <= ST_PON;
						end else if (sense_s && rst_en) begin
							state_reg <= ST_RST;
						end
					end else if (canc_s && sense_s && !wait_rel_reg
					             && canc_cnt_reg >= OFF_HOLD) begin
						canc_cnt_reg  <= 16'h0000;
						pulse_cnt_reg <= 16'h0000;
						wait_rel_reg  <= 1'b1;
						if (poff_en) begin
							state_reg <= ST_POFF;
						end
					end
				end
				ST_PON: begin
					if (tick) begin
						pulse_cnt_reg <= pulse_cnt_reg + 16'h0001;
					end
					if (pulse_cnt_reg >= width_reg) begin
						state_reg <= ST_IDLE;
					end
				end
				ST_POFF: begin
					if (tick) begin
						pulse_cnt_reg <= pulse_cnt_reg + 16'h0001;
					end
					if (pulse_cnt_reg >= width_reg) begin
						pulse_cnt_reg <= 16'h0000;
						state_reg     <= canc_s ? ST_EXTRA : ST_IDLE;
					end
				end
				ST_EXTRA: begin
					if (tick) begin
						pulse_cnt_reg <= pulse_cnt_reg + 16'h0001;
					end
					if (!canc_s || pulse_cnt_reg >= EXTRA) begin
						state_reg <= ST_IDLE;
					end
				end
				ST_RST: begin
					if (tick) begin
						pulse_cnt_reg <= pulse_cnt_reg + 16'h0001;
					end
					if (pulse_cnt_reg >= RST_LEN) begin
						state_reg  <= ST_IDLE;
						reboot_reg <= 1'b1;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================
	// Pin drive and status outputs
	reg pwr_oe_reg;
	reg rst_oe_reg;
	reg blank_reg;
	reg pwr_out_reg;
	reg rst_out_reg;
	// Levels are registered beside their enables so a pin never glitches.
	always @(posedge i_clk) begin
		if (i_rst) begin
			pwr_oe_reg  <= 1'b0;
			rst_oe_reg  <= 1'b0;
			blank_reg   <= 1'b0;
			pwr_out_reg <= 1'b1;
			rst_out_reg <= 1'b1;
		end else begin
			pwr_out_reg <= !ctrl_reg[`AHP_CTRL_PWR_INV];
			rst_out_reg <= !ctrl_reg[`AHP_CTRL_RST_INV];
			pwr_oe_reg <= (state_reg == ST_PON && pon_en)
			            || ((state_reg == ST_POFF || state_reg == ST_EXTRA) && poff_en);
			rst_oe_reg <= (state_reg == ST_RST && rst_en)
			            || ctrl_reg[`AHP_CTRL_WDOG];
			blank_reg  <= ctrl_reg[`AHP_CTRL_BLANK_EN] && !sense_s;
		end
	end
	assign o_pwr_oe  = pwr_oe_reg;
	assign o_pwr_out = pwr_out_reg;
	assign o_rst_oe  = rst_oe_reg;
	assign o_rst_out = rst_out_reg;
	assign o_blank   = blank_reg;
	assign o_self_reboot = reboot_reg;
	assign o_fan_power   = fan_reg;

	// ==========================================
	// Read channel
	always @(posedge i_clk) begin
		if (i_rst) begin
			rvalid_reg <= 1'b0;
			rresp_reg  <= 2'b00;
			rdata_reg  <= 32'h0000_0000;
		end else if (s_axi_arvalid && !rvalid_reg) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= 2'b00;
			if (s_axi_araddr == `AHP_CTRL_OFF) begin
				rdata_reg <= ctrl_reg;
			end else if (s_axi_araddr == `AHP_WIDTH_OFF) begin
				rdata_reg <= {16'h0000, width_reg};
			end else if (s_axi_araddr == `AHP_STAT_OFF) begin
				rdata_reg <= {24'h000000, rst_oe_reg, pwr_oe_reg, blank_reg, state_reg};
			end else if (s_axi_araddr == `AHP_FAN_OFF) begin
				rdata_reg <= fan_reg;
			end else begin
				rdata_reg <= 32'h0000_0000;
				rresp_reg <= 2'b10;
			end
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end
endmodule // ahp_power_ctl

// ===== pkg/ahp_consts.vh
// Constants for the host power control block: register offsets, fields and timing counts.
// Assumes a 50 MHz clock and a 32-bit AXI4-Lite register bus.
`ifndef AHP_CONSTS_VH
`define AHP_CONSTS_VH

// ==========================================
// Register offsets (byte addresses)
`define AHP_CTRL_OFF        4'h0
`define AHP_WIDTH_OFF       4'h4
`define AHP_STAT_OFF        4'h8
`define AHP_FAN_OFF         4'hc

// ==========================================
// Control register fields
`define AHP_CTRL_PON_EN     0
`define AHP_CTRL_POFF_EN    1
`define AHP_CTRL_RST_EN     2
`define AHP_CTRL_PWR_INV    3
`define AHP_CTRL_RST_INV    4
`define AHP_CTRL_BLANK_EN   5
`define AHP_CTRL_WDOG       6
`define AHP_CTRL_RESET      32'h0000_0000

// ==========================================
// Timing, in milliseconds and in clock cycles
`define AHP_CLK_HZ          50000000
`define AHP_TICK_CYC        (`AHP_CLK_HZ / 1000)
`define AHP_TICK_LAST       16'd49999
`define AHP_ON_HOLD_MS      16'd250
`define AHP_OFF_HOLD_MS     16'd4000
`define AHP_RST_HOLD_MS     16'd4000
`define AHP_RST_PULSE_MS    16'd1000
`define AHP_EXTRA_MS        16'd5000
`define AHP_WIDTH_RESET     16'd1000
`define AHP_FAN_RESET       32'h6464_6464

`endif

// ===== design/ahp_sync.v
// Two-flop synchroniser for one asynchronous level.
// Assumes the input is a level from outside the clock domain.
`timescale 1ns/10ps
module ahp_sync (
	input  wire i_clk,
	input  wire i_rst,
	input  wire i_d,
	output wire o_q
);
	reg meta_reg;
	reg sync_reg;
	always @(posedge i_clk) begin
		if (i_rst) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
		end else begin
			meta_reg <= i_d;
			sync_reg <= meta_reg;
		end
	end
	assign o_q = sync_reg;
endmodule // ahp_sync

// ===== tb/ahp_board_model.sv
// Motherboard power and reset switch inputs, each with a pull-up.
// Assumes the block hands each pin over as a separate level and drive enable.
`timescale 1ns/10ps
module ahp_board_model (
	input  logic i_clk,
	input  logic i_pwr_out,
	input  logic i_pwr_oe,
	input  logic i_rst_out,
	input  logic i_rst_oe,
	output logic o_pwr_line,
	output logic o_rst_line,
	output int   o_pwr_cycles
);
	// A released pin floats to the pull-up level.
	// Both pins are left in their default mode, never taken as user GPIO.
	assign o_pwr_line = i_pwr_oe ? i_pwr_out : 1'b1;
	assign o_rst_line = i_rst_oe ? i_rst_out : 1'b1;
	initial o_pwr_cycles = 0;
	always @(posedge i_clk) begin
		if (i_pwr_oe)
			o_pwr_cycles <= o_pwr_cycles + 1;
	end
endmodule // ahp_board_model

// ===== tb/ahp_power_ctl_asserts.sv
// Port-level checker for the host power control block.
// Assumes a single clock with synchronous active-high reset.
`timescale 1ns/10ps
module ahp_power_ctl_chk (
	input logic        i_clk,
	input logic        i_rst,
	input logic        i_sense,
	input logic        i_key_confirm,
	input logic        i_key_cancel,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic [1:0]  s_axi_bresp,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready,
	input logic [31:0] s_axi_rdata,
	input logic        o_pwr_out,
	input logic        o_pwr_oe,
	input logic        o_rst_out,
	input logic        o_rst_oe,
	input logic        o_blank,
	input logic        o_self_reboot
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// ==========================================
	// Cycles for which some key has been held without a break.
	logic [31:0] hold_cnt;
	always @(posedge i_clk) begin
		if (i_rst || !(i_key_confirm || i_key_cancel))
			hold_cnt <= 32'h0;
		else
			hold_cnt <= hold_cnt + 32'h1;
	end
	chk_pwr_hold: assert property ($rose(o_pwr_oe) |-> hold_cnt >= 32'd12450000)
		else $error("power pin driven before a full key hold");
	chk_pwr_level: assert property (o_pwr_oe && $past(o_pwr_oe) |-> $stable(o_pwr_out))
		else $error("power pin level changed inside a pulse");
	chk_rst_level: assert property (o_rst_oe && $past(o_rst_oe) |-> $stable(o_rst_out))
		else $error("reset pin level changed inside a pulse");
	chk_blank_sense: assert property (o_blank |-> !$past(i_sense, 3) || !$past(i_sense, 4))
		else $error("display blanked while host sensed on");
	chk_reboot_one: assert property (o_self_reboot |=> !o_self_reboot)
		else $error("reboot pulse longer than one cycle");
	chk_reboot_cause: assert property (o_self_reboot |-> $past(o_rst_oe) || $past(o_rst_oe, 2))
		else $error("reboot without a preceding reset pulse");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered in one cycle");
endmodule // ahp_power_ctl_chk

bind ahp_power_ctl ahp_power_ctl_chk u_chk (.*);

// ===== tb/atx_host_power_control_test.sv
// Self-checking bench for the host power control block.
// Assumes the checker is bound and the board model sits on the two pins.
`timescale 1ns/10ps
`include "ahp_consts.vh"
module atx_host_power_control_test;
	logic        i_clk, i_rst, i_sense, i_key_confirm, i_key_cancel, l0;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, o_fan_power, rd;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        o_pwr_out, o_pwr_oe, o_rst_out, o_rst_oe, o_blank, o_self_reboot;
	logic        pwr_line, rst_line;
	int          pwr_cycles, errors, total_checks;

	ahp_power_ctl dut (.*);
	ahp_board_model u_board (.i_clk(i_clk), .i_pwr_out(o_pwr_out), .i_pwr_oe(o_pwr_oe),
		.i_rst_out(o_rst_out), .i_rst_oe(o_rst_oe), .o_pwr_line(pwr_line),
		.o_rst_line(rst_line), .o_pwr_cycles(pwr_cycles));

	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	// ==========================================
	// Compare and bus tasks.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		bit aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge i_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge i_clk);
			if (s_axi_awready === 1'b1) aw_done = 1'b1;
			if (s_axi_wready === 1'b1) w_done = 1'b1;
			s_axi_awvalid <= !aw_done;
			s_axi_wvalid <= !w_done;
		end
		do @(posedge i_clk); while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
		@(posedge i_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge i_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge i_clk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		s_axi_rready <= 1'b0;
		chk(rd, exp);
	endtask
	// ==========================================
	// Scenarios.
	task t_regs;
		chk1(pwr_line, 1'b1);
		rchk(`AHP_CTRL_OFF, `AHP_CTRL_RESET);
		rchk(`AHP_WIDTH_OFF, {16'h0, `AHP_WIDTH_RESET});
		rchk(`AHP_STAT_OFF, 32'h0000_0001);
		rchk(`AHP_FAN_OFF, `AHP_FAN_RESET);
		wr(`AHP_WIDTH_OFF, 32'h1234_56c8, 4'h1);
		rchk(`AHP_WIDTH_OFF, 32'h0000_03c8);
		wr(`AHP_STAT_OFF, 32'hffff_ffff, 4'hf);
		chk({30'h0, rsp}, 32'h0000_0002);
		wr(`AHP_CTRL_OFF, 32'hffff_ffbf, 4'hf);
		rchk(`AHP_CTRL_OFF, 32'h0000_003f);
	endtask
	task t_early;
		for (int k = 0; k < 3; k++) begin
			@(posedge i_clk);
			i_sense <= (k != 0);
			i_key_confirm <= (k != 1);
			i_key_cancel <= (k == 1);
			repeat (3000) @(posedge i_clk);
			i_key_confirm <= 1'b0;
			i_key_cancel <= 1'b0;
			repeat (10) @(posedge i_clk);
		end
		chk(pwr_cycles, 32'h0);
		chk1(o_rst_oe, 1'b0);
		wr(`AHP_CTRL_OFF, 32'h0000_0000, 4'hf);
		rchk(`AHP_STAT_OFF, 32'h0000_0001);
	endtask
	task t_blank;
		wr(`AHP_CTRL_OFF, 32'h0000_0020, 4'hf);
		i_sense <= 1'b0;
		repeat (6) @(posedge i_clk);
		chk1(o_blank, 1'b1);
		rchk(`AHP_STAT_OFF, 32'h0000_0021);
		i_sense <= 1'b1;
		repeat (6) @(posedge i_clk);
		chk1(o_blank, 1'b0);
		wr(`AHP_CTRL_OFF, 32'h0000_0000, 4'hf);
		i_sense <= 1'b0;
		repeat (6) @(posedge i_clk);
		chk1(o_blank, 1'b0);
	endtask
	task t_fan;
		wr(`AHP_FAN_OFF, 32'h1122_3344, 4'hf);
		i_sense <= 1'b1;
		repeat (6) @(posedge i_clk);
		i_sense <= 1'b0;
		repeat (6) @(posedge i_clk);
		chk(o_fan_power, 32'h1122_3344);
		rchk(`AHP_FAN_OFF, 32'h1122_3344);
	endtask
	task t_wdog;
		wr(`AHP_CTRL_OFF, 32'h0000_0040, 4'hf);
		repeat (4) @(posedge i_clk);
		chk1(o_rst_oe, 1'b1);
		l0 = rst_line;
		wr(`AHP_CTRL_OFF, 32'h0000_0000, 4'hf);
		wr(`AHP_CTRL_OFF, 32'h0000_0010, 4'hf);
		wr(`AHP_CTRL_OFF, 32'h0000_0050, 4'hf);
		repeat (4) @(posedge i_clk);
		chk1(rst_line, ~l0);
		chk1(o_pwr_oe, 1'b0);
		wr(`AHP_CTRL_OFF, 32'h0000_0010, 4'hf);
		repeat (4) @(posedge i_clk);
		chk1(rst_line, 1'b1);
		wr(`AHP_CTRL_OFF, 32'h0000_0000, 4'hf);
	endtask
	task finish_test;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		{i_rst, i_sense, i_key_confirm, i_key_cancel} = 4'b1000;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 44'h0;
		errors = 0;
		total_checks = 0;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		t_regs;
		t_early;
		t_blank;
		t_fan;
		t_wdog;
		finish_test;
	end
	initial begin
		#(20 * 50000);
		errors++;
		finish_test;
	end
endmodule // atx_host_power_control_test
